// ---- design/pss_pkg.sv ----
// Package for the peripheral sleep status block: offsets, bit positions, reset values
package pss_pkg;

	// Register index as printed; byte address is four times the index
	localparam logic [15:0] PSS_STATUS_IDX       = 16'h9401;
	localparam logic [17:0] PSS_STATUS_ADDR      = {PSS_STATUS_IDX, 2'b00};
	// Control registers placed next to the status word
	localparam logic [15:0] PSS_CTRL_IDX         = 16'h9400;
	localparam logic [17:0] PSS_CTRL_ADDR        = {PSS_CTRL_IDX, 2'b00};
	localparam logic [15:0] PSS_STATE_IDX        = 16'h9402;
	localparam logic [17:0] PSS_STATE_ADDR       = {PSS_STATE_IDX, 2'b00};

	localparam int          PSS_WIDTH            = 16;
	localparam int          PSS_BIT_MISC         = 13;
	localparam int          PSS_BIT_EXT_MEM      = 12;
	localparam int          PSS_BIT_OS_TIMER     = 11;
	localparam int          PSS_BIT_WATCHDOG     = 10;
	localparam int          PSS_BIT_PAR_PORT     = 9;
	localparam int          PSS_BIT_ASYNC_SER    = 8;
	localparam int          PSS_BIT_I2C          = 7;
	localparam int          PSS_BIT_AUX_UNIT     = 6;
	localparam int          PSS_BIT_GPIO         = 5;
	localparam int          PSS_BIT_SER_ONE      = 3;
	localparam int          PSS_BIT_SER_ZERO     = 2;
	localparam int          PSS_BIT_TIMER_ONE    = 1;
	localparam int          PSS_BIT_TIMER_ZERO   = 0;
	localparam int          PSS_BIT_SLEEP_STATE  = 0;

	// Implemented flag bits: 13..5 and 3..0; bits 15, 14 and 4 read zero
	localparam logic [15:0] PSS_FLAG_MASK        = 16'h3FEF;
	localparam logic [15:0] PSS_RESET_VAL        = 16'h0000;
	localparam logic [31:0] PSS_UNMAPPED_DATA    = 32'h0000_0000;

endpackage

// ---- design/pss_peripheral_sleep_status.sv ----
// Peripheral sleep control and read-only sleep status with an Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none

module pss_peripheral_sleep_status
	import pss_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic [17:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output var  logic [31:0] avs_readdata,
	output var  logic        avs_waitrequest,
	input  wire logic        idleExec,
	output var  logic [15:0] periphSleep
);

	logic [15:0] sleepCtrl_q;
	logic [15:0] sleepCtrl_d;
	logic        sleepState_q;
	logic        sleepState_d;
	logic [15:0] status_q;
	logic [15:0] status_d;
	logic [31:0] readData_q;
	logic [31:0] readData_d;
	logic        ack_q;
	logic        ack_d;
	logic        waitReq_q;
	logic        waitReq_d;
	logic [15:0] periphSleep_q;
	logic        access;

	assign access = (avs_read | avs_write) & ~ack_q;

	// Bus slave: one wait cycle, answer on the second edge
	always_comb begin
		ack_d = access;
		waitReq_d = ~access;
		readData_d = readData_q;
		sleepCtrl_d = sleepCtrl_q;
		sleepState_d = sleepState_q;
		if (access && avs_read) begin
			unique case (avs_address)
				PSS_STATUS_ADDR: readData_d = {16'h0000, status_q & PSS_FLAG_MASK};
				PSS_CTRL_ADDR:   readData_d = {16'h0000, sleepCtrl_q & PSS_FLAG_MASK};
				PSS_STATE_ADDR:  readData_d = {31'h0000_0000, sleepState_q};
				default:         readData_d = PSS_UNMAPPED_DATA;
			endcase
		end
		if (access && avs_write) begin
			unique case (avs_address)
				PSS_CTRL_ADDR: begin
					if (avs_byteenable[0])
						sleepCtrl_d[7:0] = avs_writedata[7:0] & PSS_FLAG_MASK[7:0];
					if (avs_byteenable[1])
						sleepCtrl_d[15:8] = avs_writedata[15:8] & PSS_FLAG_MASK[15:8];
				end
				PSS_STATE_ADDR: begin
					if (avs_byteenable[0])
						sleepState_d = avs_writedata[PSS_BIT_SLEEP_STATE];
				end
				// Status writes and unmapped writes are dropped
				default: ;
			endcase
		end
	end

	// Sleep state update on each IDLE execution
	always_comb begin
		status_d = status_q;
		if (idleExec) begin
			if (sleepState_q)
				status_d = sleepCtrl_q & PSS_FLAG_MASK;
			else
				status_d = PSS_RESET_VAL;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sleepCtrl_q <= PSS_RESET_VAL;
			sleepState_q <= 1'b0;
			status_q <= PSS_RESET_VAL;
			readData_q <= 32'h0000_0000;
			ack_q <= 1'b0;
			waitReq_q <= 1'b1;
			periphSleep_q <= PSS_RESET_VAL;
		end else begin
			sleepCtrl_q <= sleepCtrl_d;
			sleepState_q <= sleepState_d;
			status_q <= status_d;
			readData_q <= readData_d;
			ack_q <= ack_d;
			waitReq_q <= waitReq_d;
			periphSleep_q <= status_d;
		end
	end

	// Bit layout of the status word to the peripheral gating lines
	always_comb begin
		periphSleep = periphSleep_q;
		periphSleep[PSS_BIT_MISC] = periphSleep_q[PSS_BIT_MISC];
		periphSleep[PSS_BIT_EXT_MEM] = periphSleep_q[PSS_BIT_EXT_MEM];
		periphSleep[PSS_BIT_OS_TIMER] = periphSleep_q[PSS_BIT_OS_TIMER];
		periphSleep[PSS_BIT_WATCHDOG] = periphSleep_q[PSS_BIT_WATCHDOG];
		periphSleep[PSS_BIT_PAR_PORT] = periphSleep_q[PSS_BIT_PAR_PORT];
		periphSleep[PSS_BIT_ASYNC_SER] = periphSleep_q[PSS_BIT_ASYNC_SER];
		periphSleep[PSS_BIT_I2C] = periphSleep_q[PSS_BIT_I2C];
		periphSleep[PSS_BIT_AUX_UNIT] = periphSleep_q[PSS_BIT_AUX_UNIT];
		periphSleep[PSS_BIT_GPIO] = periphSleep_q[PSS_BIT_GPIO];
		periphSleep[PSS_BIT_SER_ONE] = periphSleep_q[PSS_BIT_SER_ONE];
		periphSleep[PSS_BIT_SER_ZERO] = periphSleep_q[PSS_BIT_SER_ZERO];
		periphSleep[PSS_BIT_TIMER_ONE] = periphSleep_q[PSS_BIT_TIMER_ONE];
		periphSleep[PSS_BIT_TIMER_ZERO] = periphSleep_q[PSS_BIT_TIMER_ZERO];
	end

	assign avs_readdata = readData_q;
	assign avs_waitrequest = waitReq_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	AST_RESERVED_ZERO: assert property ((status_q & ~PSS_FLAG_MASK) == 16'h0000)
		else $error("reserved status bit set");
	AST_STATUS_WRITE_IGNORED: assert property (
		(access && avs_write && avs_address == PSS_STATUS_ADDR && !idleExec) |=> $stable(status_q))
		else $error("status changed by write");
	AST_SLEEP_ENTRY: assert property (
		(idleExec && sleepState_q) |=> (status_q == ($past(sleepCtrl_q) & PSS_FLAG_MASK)))
		else $error("sleep entry wrong");
	AST_WAKE_ALL: assert property ((idleExec && !sleepState_q) |=> status_q == 16'h0000)
		else $error("wake without sleep state failed");
	AST_NO_IDLE_HOLD: assert property (!idleExec && !(access && avs_write) |=> $stable(status_q))
		else $error("status changed without IDLE");
	AST_WAKE_UNSELECTED: assert property (
		(idleExec && sleepState_q && !sleepCtrl_q[PSS_BIT_MISC]) |=> !status_q[PSS_BIT_MISC])
		else $error("unselected group not woken");
	AST_EXT_MEM_FLAG: assert property (
		(idleExec && sleepState_q && sleepCtrl_q[PSS_BIT_EXT_MEM]) |=> periphSleep[PSS_BIT_EXT_MEM])
		else $error("ext mem flag not set");
	AST_READ_ANSWER: assert property (
		(access && avs_read && avs_address == PSS_STATUS_ADDR && !idleExec)
		|=> !avs_waitrequest && avs_readdata[15:0] == status_q && avs_readdata[31:16] == 16'h0000)
		else $error("status read wrong");
	AST_TIMER_ZERO_FLAG: assert property (
		(idleExec && sleepState_q) |=> periphSleep[PSS_BIT_TIMER_ZERO] == $past(sleepCtrl_q[0]))
		else $error("timer zero flag wrong");
	AST_WAIT_BOUND: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
		else $error("bus answer late");

	// Bus slave timing and register effects
	AST_ONE_WAIT: assert property (access |=> !avs_waitrequest)
		else $error("answer not one cycle after request");
	AST_WAIT_HIGH: assert property (!access |=> avs_waitrequest)
		else $error("waitrequest low without request");
	AST_READDATA_HOLD: assert property (!(access && avs_read) |=> $stable(avs_readdata))
		else $error("read data moved without read");
	AST_CTRL_WRITE: assert property (
		(access && avs_write && avs_address == PSS_CTRL_ADDR && avs_byteenable[1:0] == 2'b11)
		|=> sleepCtrl_q == ($past(avs_writedata[15:0]) & PSS_FLAG_MASK))
		else $error("control write lost");
	AST_STATE_WRITE: assert property (
		(access && avs_write && avs_address == PSS_STATE_ADDR && avs_byteenable[0])
		|=> sleepState_q == $past(avs_writedata[PSS_BIT_SLEEP_STATE]))
		else $error("sleep state write lost");
	AST_UNMAPPED_READ: assert property (
		(access && avs_read && avs_address != PSS_STATUS_ADDR
		&& avs_address != PSS_CTRL_ADDR && avs_address != PSS_STATE_ADDR)
		|=> avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	AST_OUT_MATCH: assert property (periphSleep == status_q)
		else $error("gating lines differ from status");

	// Reserved status bits
	AST_RSV_BIT15: assert property (!periphSleep[15])
		else $error("bit 15 set");
	AST_RSV_BIT14: assert property (!periphSleep[14])
		else $error("bit 14 set");
	AST_RSV_BIT4: assert property (!periphSleep[4])
		else $error("bit 4 set");

	// Each flag takes its select bit on sleep entry
	AST_GLUE_FLAG: assert property (
		(idleExec && sleepState_q)
		|=> periphSleep[PSS_BIT_MISC] == $past(sleepCtrl_q[PSS_BIT_MISC]))
		else $error("glue group flag wrong");
	AST_EXT_MEM_FOLLOW: assert property (
		(idleExec && sleepState_q)
		|=> periphSleep[PSS_BIT_EXT_MEM] == $past(sleepCtrl_q[PSS_BIT_EXT_MEM]))
		else $error("ext mem flag wrong");
	AST_OS_TIMER_FLAG: assert property (
		(idleExec && sleepState_q)
		|=> periphSleep[PSS_BIT_OS_TIMER] == $past(sleepCtrl_q[PSS_BIT_OS_TIMER]))
		else $error("os timer flag wrong");
	AST_WATCHDOG_FLAG: assert property (
		(idleExec && sleepState_q)
		|=> periphSleep[PSS_BIT_WATCHDOG] == $past(sleepCtrl_q[PSS_BIT_WATCHDOG]))
		else $error("watchdog flag wrong");
	AST_PAR_PORT_FLAG: assert property (
		(idleExec && sleepState_q)
		|=> periphSleep[PSS_BIT_PAR_PORT] == $past(sleepCtrl_q[PSS_BIT_PAR_PORT]))
		else $error("parallel port flag wrong");
	AST_ASYNC_SER_FLAG: assert property (
		(idleExec && sleepState_q)
		|=> periphSleep[PSS_BIT_ASYNC_SER] == $past(sleepCtrl_q[PSS_BIT_ASYNC_SER]))
		else $error("async serial flag wrong");
	AST_I2C_FLAG: assert property (
		(idleExec && sleepState_q)
		|=> periphSleep[PSS_BIT_I2C] == $past(sleepCtrl_q[PSS_BIT_I2C]))
		else $error("i2c flag wrong");
	AST_AUX_UNIT_FLAG: assert property (
		(idleExec && sleepState_q)
		|=> periphSleep[PSS_BIT_AUX_UNIT] == $past(sleepCtrl_q[PSS_BIT_AUX_UNIT]))
		else $error("aux unit flag wrong");
	AST_GPIO_FLAG: assert property (
		(idleExec && sleepState_q)
		|=> periphSleep[PSS_BIT_GPIO] == $past(sleepCtrl_q[PSS_BIT_GPIO]))
		else $error("gpio flag wrong");
	AST_SER_ONE_FLAG: assert property (
		(idleExec && sleepState_q)
		|=> periphSleep[PSS_BIT_SER_ONE] == $past(sleepCtrl_q[PSS_BIT_SER_ONE]))
		else $error("serial one flag wrong");
	AST_SER_ZERO_FLAG: assert property (
		(idleExec && sleepState_q)
		|=> periphSleep[PSS_BIT_SER_ZERO] == $past(sleepCtrl_q[PSS_BIT_SER_ZERO]))
		else $error("serial zero flag wrong");
	AST_TIMER_ONE_FLAG: assert property (
		(idleExec && sleepState_q)
		|=> periphSleep[PSS_BIT_TIMER_ONE] == $past(sleepCtrl_q[PSS_BIT_TIMER_ONE]))
		else $error("timer one flag wrong");

	// IDLE with the sleep state flag clear wakes every flag
	AST_GLUE_WAKE: assert property (
		(idleExec && !sleepState_q) |=> !periphSleep[PSS_BIT_MISC])
		else $error("glue group not woken");
	AST_EXT_MEM_WAKE: assert property (
		(idleExec && !sleepState_q) |=> !periphSleep[PSS_BIT_EXT_MEM])
		else $error("ext mem not woken");
	AST_OS_TIMER_WAKE: assert property (
		(idleExec && !sleepState_q) |=> !periphSleep[PSS_BIT_OS_TIMER])
		else $error("os timer not woken");
	AST_WATCHDOG_WAKE: assert property (
		(idleExec && !sleepState_q) |=> !periphSleep[PSS_BIT_WATCHDOG])
		else $error("watchdog not woken");
	AST_PAR_PORT_WAKE: assert property (
		(idleExec && !sleepState_q) |=> !periphSleep[PSS_BIT_PAR_PORT])
		else $error("parallel port not woken");
	AST_ASYNC_SER_WAKE: assert property (
		(idleExec && !sleepState_q) |=> !periphSleep[PSS_BIT_ASYNC_SER])
		else $error("async serial not woken");
	AST_I2C_WAKE: assert property (
		(idleExec && !sleepState_q) |=> !periphSleep[PSS_BIT_I2C])
		else $error("i2c not woken");
	AST_AUX_UNIT_WAKE: assert property (
		(idleExec && !sleepState_q) |=> !periphSleep[PSS_BIT_AUX_UNIT])
		else $error("aux unit not woken");
	AST_GPIO_WAKE: assert property (
		(idleExec && !sleepState_q) |=> !periphSleep[PSS_BIT_GPIO])
		else $error("gpio not woken");
	AST_SER_ONE_WAKE: assert property (
		(idleExec && !sleepState_q) |=> !periphSleep[PSS_BIT_SER_ONE])
		else $error("serial one not woken");
	AST_SER_ZERO_WAKE: assert property (
		(idleExec && !sleepState_q) |=> !periphSleep[PSS_BIT_SER_ZERO])
		else $error("serial zero not woken");
	AST_TIMER_ONE_WAKE: assert property (
		(idleExec && !sleepState_q) |=> !periphSleep[PSS_BIT_TIMER_ONE])
		else $error("timer one not woken");
	AST_TIMER_ZERO_WAKE: assert property (
		(idleExec && !sleepState_q) |=> !periphSleep[PSS_BIT_TIMER_ZERO])
		else $error("timer zero not woken");

	// IDLE in sleep state wakes each unselected peripheral
	AST_EXT_MEM_UNSEL: assert property (
		(idleExec && sleepState_q && !sleepCtrl_q[PSS_BIT_EXT_MEM]) |=> !status_q[PSS_BIT_EXT_MEM])
		else $error("ext mem not woken");
	AST_OS_TIMER_UNSEL: assert property (
		(idleExec && sleepState_q && !sleepCtrl_q[PSS_BIT_OS_TIMER]) |=> !status_q[PSS_BIT_OS_TIMER])
		else $error("os timer not woken");
	AST_WATCHDOG_UNSEL: assert property (
		(idleExec && sleepState_q && !sleepCtrl_q[PSS_BIT_WATCHDOG]) |=> !status_q[PSS_BIT_WATCHDOG])
		else $error("watchdog not woken");
	AST_PAR_PORT_UNSEL: assert property (
		(idleExec && sleepState_q && !sleepCtrl_q[PSS_BIT_PAR_PORT]) |=> !status_q[PSS_BIT_PAR_PORT])
		else $error("parallel port not woken");
	AST_ASYNC_SER_UNSEL: assert property (
		(idleExec && sleepState_q && !sleepCtrl_q[PSS_BIT_ASYNC_SER])
		|=> !status_q[PSS_BIT_ASYNC_SER])
		else $error("async serial not woken");
	AST_I2C_UNSEL: assert property (
		(idleExec && sleepState_q && !sleepCtrl_q[PSS_BIT_I2C]) |=> !status_q[PSS_BIT_I2C])
		else $error("i2c not woken");
	AST_AUX_UNIT_UNSEL: assert property (
		(idleExec && sleepState_q && !sleepCtrl_q[PSS_BIT_AUX_UNIT]) |=> !status_q[PSS_BIT_AUX_UNIT])
		else $error("aux unit not woken");
	AST_GPIO_UNSEL: assert property (
		(idleExec && sleepState_q && !sleepCtrl_q[PSS_BIT_GPIO]) |=> !status_q[PSS_BIT_GPIO])
		else $error("gpio not woken");
	AST_SER_ONE_UNSEL: assert property (
		(idleExec && sleepState_q && !sleepCtrl_q[PSS_BIT_SER_ONE]) |=> !status_q[PSS_BIT_SER_ONE])
		else $error("serial one not woken");
	AST_SER_ZERO_UNSEL: assert property (
		(idleExec && sleepState_q && !sleepCtrl_q[PSS_BIT_SER_ZERO]) |=> !status_q[PSS_BIT_SER_ZERO])
		else $error("serial zero not woken");
	AST_TIMER_ONE_UNSEL: assert property (
		(idleExec && sleepState_q && !sleepCtrl_q[PSS_BIT_TIMER_ONE])
		|=> !status_q[PSS_BIT_TIMER_ONE])
		else $error("timer one not woken");
	AST_TIMER_ZERO_UNSEL: assert property (
		(idleExec && sleepState_q && !sleepCtrl_q[PSS_BIT_TIMER_ZERO])
		|=> !status_q[PSS_BIT_TIMER_ZERO])
		else $error("timer zero not woken");

	COV_SLEEP: cover property (idleExec && sleepState_q && sleepCtrl_q != 16'h0000);
	COV_WAKE: cover property ((status_q != 16'h0000) ##1 idleExec && !sleepState_q);
	COV_STATUS_READ: cover property (access && avs_read && avs_address == PSS_STATUS_ADDR);
	COV_CTRL_WRITE: cover property (access && avs_write && avs_address == PSS_CTRL_ADDR);

endmodule

`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the peripheral sleep status block
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import pss_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [17:0] avs_address = 18'h0_0000;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0]  avs_byteenable = 4'h3;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        idleExec = 1'b0;
	logic [15:0] periphSleep;
	logic [31:0] rdData;
	int          errors = 0;
	int          compares = 0;
	int          cycles = 0;

	pss_peripheral_sleep_status pss_peripheral_sleep_status_inst (
		.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .idleExec(idleExec), .periphSleep(periphSleep));

	always #20 core_clk = ~core_clk;

	task automatic report_and_stop();
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Ceiling well above the few hundred cycles the scenarios need
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// Request held until waitrequest is sampled low, one idle edge after release
	task automatic bus(input logic [17:0] a, input logic w, input logic [15:0] d);
		avs_address   <= a;
		avs_write     <= w;
		avs_read      <= ~w;
		avs_writedata <= {16'h0000, d};
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0) @(posedge core_clk);
		rdData = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic idle(input logic [15:0] ctl, input logic st);
		bus(PSS_CTRL_ADDR, 1'b1, ctl);
		bus(PSS_STATE_ADDR, 1'b1, {15'h0000, st});
		idleExec <= 1'b1;
		@(posedge core_clk);
		idleExec <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic status(input logic [15:0] e);
		bus(PSS_STATUS_ADDR, 1'b0, 16'h0000);
		chk(rdData, {16'h0000, e});
		chk({16'h0000, periphSleep}, {16'h0000, e});
	endtask

	// One peripheral at a time; each IDLE also wakes the one selected before
	task automatic t_bits();
		for (int i = 0; i < 16; i++) begin
			idle(16'h0001 << i, 1'b1);
			status((16'h0001 << i) & 16'h3FEF);
		end
	endtask

	task automatic t_gating();
		idle(16'hFFFF, 1'b1);
		status(16'h3FEF);
		bus(PSS_CTRL_ADDR, 1'b1, 16'h0000);
		status(16'h3FEF);
		idle(16'h0005, 1'b1);
		status(16'h0005);
		idle(16'h3FEF, 1'b0);
		status(16'h0000);
		bus(PSS_STATE_ADDR, 1'b1, 16'h0001);
		status(16'h0000);
	endtask

	task automatic t_refuse();
		idle(16'h0102, 1'b1);
		bus(PSS_STATUS_ADDR, 1'b1, 16'hFFFF);
		status(16'h0102);
		bus(18'h0_0010, 1'b1, 16'hFFFF);
		bus(18'h0_0010, 1'b0, 16'h0000);
		chk(rdData, 32'h0000_0000);
	endtask

	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		status(16'h0000);
		t_bits();
		t_gating();
		t_refuse();
		report_and_stop();
	end
endmodule
`default_nettype wire
